// ---- core/hcr_regs.svh ----
// Purpose: Shared constants of the command/result port and its host bridge
// Assumes: Included by bare name from the package and both ends
// Notes:   Link selects, status bits, command codes and host offsets
`ifndef HCR_REGS_SVH
`define HCR_REGS_SVH
// ==========================================================
// Link register selects (two address bits)
`define HCR_SEL_CMD 2'h0
`define HCR_SEL_PARAM 2'h1
`define HCR_SEL_TXIR 2'h2
`define HCR_SEL_RXIR 2'h3
// ==========================================================
// Status word bit positions
`define HCR_ST_BUSY 7
`define HCR_ST_CMD_FULL 6
`define HCR_ST_PAR_FULL 5
`define HCR_ST_RES_FULL 4
`define HCR_ST_RX_ATTN 3
`define HCR_ST_TX_ATTN 2
`define HCR_ST_RX_AVAIL 1
`define HCR_ST_TX_AVAIL 0
// ==========================================================
// Command codes
`define HCR_CMD_SET_MODE 8'h91
`define HCR_CMD_RST_MODE 8'h51
`define HCR_CMD_SET_SIO 8'hA0
`define HCR_CMD_RST_SIO 8'h60
`define HCR_CMD_SET_OBD 8'hA4
`define HCR_CMD_RST_OBD 8'h64
`define HCR_CMD_SET_XFER 8'h97
`define HCR_CMD_RST_XFER 8'h57
`define HCR_CMD_RECEIVE 8'hC0
`define HCR_CMD_TRANSMIT 8'hC8
`define HCR_CMD_READ_PORTA 8'h22
`define HCR_MAX_PARAMS 3'h4
// ==========================================================
// Mode bits, frame bytes and result codes
`define HCR_MODE_HDLC 5
`define HCR_MODE_BUFFERED 2
`define HCR_MODE_RESET 8'h00
`define HCR_FLAG_BYTE 8'h7E
`define HCR_FCS_BYTE 8'h00
`define HCR_TX_DONE_CODE 8'h0C
`define HCR_RX_DONE_CODE 5'h00
`define HCR_RX_ABORT_CODE 5'h08
`define HCR_ABORT_RUN_HDLC 4'h7
`define HCR_ABORT_RUN_SDLC 4'h8
// ==========================================================
// Host APB offsets
`define HCR_APB_STATUS 8'h00
`define HCR_APB_RESULT 8'h04
`define HCR_APB_TXIR 8'h08
`define HCR_APB_RXIR 8'h0C
`define HCR_APB_RXDATA 8'h10
`define HCR_APB_PINS 8'h14
`endif

// ---- core/hcr_pkg.sv ----
// Purpose: Types shared by both ends of the command/result port
// Assumes: Constants come from hcr_regs.svh
// Notes:   Host and buffered-transmit state encodings are Gray along the usual path
package hcr_pkg;
`include "hcr_regs.svh"
   typedef enum logic [1:0] {HCR_CS_IDLE = 2'h0, HCR_CS_PARAM = 2'h1, HCR_CS_EXEC = 2'h3} hcr_cmd_state_type;
   typedef enum logic [2:0] {HCR_TX_IDLE = 3'h0, HCR_TX_FLAG = 3'h1, HCR_TX_ADDR = 3'h3, HCR_TX_CTRL = 3'h2,
      HCR_TX_DATA = 3'h6, HCR_TX_FCS = 3'h7, HCR_TX_CLOSE = 3'h5, HCR_TX_DONE = 3'h4} hcr_tx_state_type;
   typedef enum logic [1:0] {HCR_KIND_FLAG = 2'h0, HCR_KIND_DATA = 2'h1, HCR_KIND_FCS = 2'h2} hcr_kind_type;
   typedef enum logic [1:0] {HCR_HS_IDLE = 2'h0, HCR_HS_STRB = 2'h1, HCR_HS_CAPT = 2'h3, HCR_HS_RESP = 2'h2} hcr_host_state_type;
endpackage

// ---- core/hcr_link_if.sv ----
// Purpose: Parallel microprocessor bus between host bridge and controller
// Assumes: All strobes are synchronous to the shared clock
// Notes:   Active-low strobes, one cycle per access
`timescale 1ns/1ns
interface hcr_link_if;
   logic cs_n;
   logic rd_n;
   logic wr_n;
   logic [1:0] addr;
   logic [7:0] wdata;
   logic tx_dack_n;
   logic rx_dack_n;
   logic [7:0] rdata;
   logic tx_int;
   logic rx_int;
   logic tx_drq;
   logic rx_drq;
   modport dev (input cs_n, rd_n, wr_n, addr, wdata, tx_dack_n, rx_dack_n,
      output rdata, tx_int, rx_int, tx_drq, rx_drq);
   modport host (output cs_n, rd_n, wr_n, addr, wdata, tx_dack_n, rx_dack_n,
      input rdata, tx_int, rx_int, tx_drq, rx_drq);
endinterface // hcr_link_if

// ---- core/hcr_device.sv ----
// Purpose: Command, status and result sequencer of the frame controller
// Assumes: Strobes last one cycle; serial line logic sits outside
// Notes:   Byte-level frame stream out, bit-level receive tap for abort
`timescale 1ns/1ns
`include "hcr_regs.svh"
// Contract
// - Status word bit order busy to tx-avail
// - Busy set on command, cleared after params
// - Host never writes command while busy
// - Command-full cleared when byte taken
// - Parameter-full cleared when byte accepted
// - Host sends at most four parameters
// - Result-full set on immediate result, read clears
// - Receive attention mirrors pin, read clears
// - Transmit attention mirrors pin, result read or data write clears
// - Result-available set on load, read clears
// - Execute after last parameter, per-byte interrupts
// - Result phase on success or error
// - Immediate or interrupt result register placement
// - Code top bits zero except receive
// - Host reads every result byte
// - Duplex operation, one command sequence only
// - Buffered transmit: flag, address, control, data
// - Unbuffered transmit: flag, fields, FCS, flag
// - Unbuffered receive delivers all but flags/FCS
// - HDLC abort on seven consecutive ones
// - Set ORs mask, reset ANDs mask
// - One-bit delay entered at character boundary
// - Attention without result means data request
module hcr_device (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Host bus
   hcr_link_if.dev link,
   // Modem input port
   input wire logic [7:0] port_a_in,
   // Transmit byte stream to line logic
   output logic [7:0] tx_byte_out,
   output hcr_pkg::hcr_kind_type tx_kind_out,
   output logic tx_valid_out,
   input wire logic tx_ready_in,
   // Receive byte stream from line logic
   input wire logic [7:0] rx_byte_in,
   input wire logic rx_byte_valid_in,
   input wire logic rx_end_in,
   input wire logic [2:0] rx_end_bits_in,
   // Receive bit tap and one-bit repeater
   input wire logic rx_bit_in,
   input wire logic rx_bit_valid_in,
   output logic delay_bit_out,
   output logic delay_bit_valid_out,
   output logic abort_out,
   // Mode registers
   output logic [7:0] op_mode_out,
   output logic [7:0] sio_mode_out,
   output logic xfer_mode_out
);
   import hcr_pkg::*;

   // ==========================================================
   // Bus decode
   wire wr_cs = !link.cs_n && !link.wr_n;
   wire rd_cs = !link.cs_n && !link.rd_n;
   wire cmd_wr = wr_cs && link.addr == `HCR_SEL_CMD;
   wire par_wr = wr_cs && link.addr == `HCR_SEL_PARAM;
   wire res_rd = rd_cs && link.addr == `HCR_SEL_PARAM;
   wire txir_rd = rd_cs && link.addr == `HCR_SEL_TXIR;
   wire rxir_rd = rd_cs && link.addr == `HCR_SEL_RXIR;
   wire txd_wr = !link.tx_dack_n && !link.wr_n;
   wire rxd_rd = !link.rx_dack_n && !link.rd_n;

   logic busy, cmd_full, par_full, res_full, tx_avail;
   logic [7:0] cmd_buf, par_buf, cmd_q, result_q, tx_ir;
   logic [7:0] par_q [0:3];
   logic [2:0] par_cnt;
   hcr_cmd_state_type cmd_state;
   logic obd_req, obd_on, tx_start, rx_start;
   hcr_tx_state_type tx_state;
   logic [15:0] tx_left, rx_cnt;
   logic [7:0] tx_buf, rx_data, rx_a, rx_c;
   logic tx_full, rx_on, rx_full;
   logic [1:0] rx_hdr;
   logic [7:0] rq [0:4];
   logic [2:0] rq_len, rq_ptr;
   logic [3:0] ones;
   logic [2:0] bit_pos;
   logic prev_bit;

   wire buffered = op_mode_out[`HCR_MODE_BUFFERED];
   wire rx_avail = rq_ptr != rq_len;
   wire tx_req = tx_state == HCR_TX_DATA && !tx_full && tx_left != 16'h0000;
   wire [3:0] abort_run = op_mode_out[`HCR_MODE_HDLC] ? `HCR_ABORT_RUN_HDLC : `HCR_ABORT_RUN_SDLC;
   wire [3:0] ones_inc = ones + 4'h1;
   wire abort_hit = rx_bit_valid_in && rx_bit_in && ones_inc == abort_run;
   wire [7:0] status = {busy, cmd_full, par_full, res_full,
      link.rx_int, link.tx_int, rx_avail, tx_avail};

   // Data requests go to DMA or, in data transfer mode, to the attention pins
   assign link.tx_int = tx_avail || (tx_req && xfer_mode_out);
   assign link.rx_int = rx_avail || (rx_full && xfer_mode_out);
   assign link.tx_drq = tx_req && !xfer_mode_out;
   assign link.rx_drq = rx_full && !xfer_mode_out;

   function automatic logic [2:0] params_needed(input logic [7:0] code, input logic buf_mode);
      case (code)
         `HCR_CMD_SET_MODE, `HCR_CMD_RST_MODE, `HCR_CMD_SET_SIO, `HCR_CMD_RST_SIO: params_needed = 3'h1;
         `HCR_CMD_RECEIVE: params_needed = 3'h2;
         `HCR_CMD_TRANSMIT: params_needed = buf_mode ? `HCR_MAX_PARAMS : 3'h2;
         default: params_needed = 3'h0;
      endcase
   endfunction

   wire [2:0] need_now = params_needed(cmd_buf, buffered);
   wire [2:0] need_q = params_needed(cmd_q, buffered);

   // ==========================================================
   // Command phase
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         busy <= 1'h0;
         cmd_full <= 1'h0;
         par_full <= 1'h0;
         res_full <= 1'h0;
         cmd_buf <= 8'h00;
         par_buf <= 8'h00;
         cmd_q <= 8'h00;
         result_q <= 8'h00;
         par_cnt <= 3'h0;
         cmd_state <= HCR_CS_IDLE;
         op_mode_out <= `HCR_MODE_RESET;
         sio_mode_out <= `HCR_MODE_RESET;
         xfer_mode_out <= 1'h0;
         obd_req <= 1'h0;
         tx_start <= 1'h0;
         rx_start <= 1'h0;
         for (int i = 0; i < 4; i++) begin
            par_q[i] <= 8'h00;
         end
      end else begin
         tx_start <= 1'h0;
         rx_start <= 1'h0;
         if (res_rd) begin
            res_full <= 1'h0;
         end
         case (cmd_state)
            HCR_CS_IDLE: begin
               if (cmd_full) begin
                  cmd_full <= 1'h0;
                  cmd_q <= cmd_buf;
                  par_cnt <= 3'h0;
                  cmd_state <= (need_now == 3'h0) ? HCR_CS_EXEC : HCR_CS_PARAM;
               end
            end
            HCR_CS_PARAM: begin
               if (par_full) begin
                  par_full <= 1'h0;
                  par_q[par_cnt[1:0]] <= par_buf;
                  par_cnt <= par_cnt + 3'h1;
                  if (par_cnt + 3'h1 == need_q) begin
                     cmd_state <= HCR_CS_EXEC;
                  end
               end
            end
            HCR_CS_EXEC: begin
               busy <= 1'h0;
               cmd_state <= HCR_CS_IDLE;
               case (cmd_q)
                  `HCR_CMD_SET_MODE: op_mode_out <= op_mode_out | par_q[0];
                  `HCR_CMD_RST_MODE: op_mode_out <= op_mode_out & par_q[0];
                  `HCR_CMD_SET_SIO: sio_mode_out <= sio_mode_out | par_q[0];
                  `HCR_CMD_RST_SIO: sio_mode_out <= sio_mode_out & par_q[0];
                  `HCR_CMD_SET_OBD: obd_req <= 1'h1;
                  `HCR_CMD_RST_OBD: obd_req <= 1'h0;
                  `HCR_CMD_SET_XFER: xfer_mode_out <= 1'h1;
                  `HCR_CMD_RST_XFER: xfer_mode_out <= 1'h0;
                  `HCR_CMD_RECEIVE: rx_start <= 1'h1;
                  `HCR_CMD_TRANSMIT: tx_start <= 1'h1;
                  `HCR_CMD_READ_PORTA: begin
                     result_q <= port_a_in;
                     res_full <= 1'h1;
                  end
                  default: ;
               endcase
            end
            default: cmd_state <= HCR_CS_IDLE;
         endcase
         // A new write wins over the take in the same cycle
         if (cmd_wr) begin
            cmd_buf <= link.wdata;
            cmd_full <= 1'h1;
            busy <= 1'h1;
         end
         if (par_wr) begin
            par_buf <= link.wdata;
            par_full <= 1'h1;
         end
      end
   end

   // ==========================================================
   // Read data
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         link.rdata <= 8'h00;
      end else if (rxd_rd) begin
         link.rdata <= rx_data;
      end else if (rd_cs) begin
         case (link.addr)
            `HCR_SEL_CMD: link.rdata <= status;
            `HCR_SEL_PARAM: link.rdata <= result_q;
            `HCR_SEL_TXIR: link.rdata <= tx_ir;
            default: link.rdata <= rq[rq_ptr];
         endcase
      end
   end

   // ==========================================================
   // Transmit framing
   wire tx_free = !tx_valid_out || tx_ready_in;
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tx_state <= HCR_TX_IDLE;
         tx_left <= 16'h0000;
         tx_buf <= 8'h00;
         tx_full <= 1'h0;
         tx_avail <= 1'h0;
         tx_ir <= 8'h00;
         tx_byte_out <= 8'h00;
         tx_kind_out <= HCR_KIND_FLAG;
         tx_valid_out <= 1'h0;
      end else begin
         if (tx_valid_out && tx_ready_in) begin
            tx_valid_out <= 1'h0;
         end
         if (txir_rd) begin
            tx_avail <= 1'h0;
         end
         case (tx_state)
            HCR_TX_IDLE: begin
               if (tx_start) begin
                  tx_left <= {par_q[1], par_q[0]};
                  tx_state <= HCR_TX_FLAG;
               end
            end
            HCR_TX_FLAG: if (tx_free) begin
               tx_byte_out <= `HCR_FLAG_BYTE;
               tx_kind_out <= HCR_KIND_FLAG;
               tx_valid_out <= 1'h1;
               tx_state <= buffered ? HCR_TX_ADDR : HCR_TX_DATA;
            end
            HCR_TX_ADDR: if (tx_free) begin
               tx_byte_out <= par_q[2];
               tx_kind_out <= HCR_KIND_DATA;
               tx_valid_out <= 1'h1;
               tx_state <= HCR_TX_CTRL;
            end
            HCR_TX_CTRL: if (tx_free) begin
               tx_byte_out <= par_q[3];
               tx_kind_out <= HCR_KIND_DATA;
               tx_valid_out <= 1'h1;
               tx_state <= HCR_TX_DATA;
            end
            HCR_TX_DATA: begin
               if (tx_left == 16'h0000) begin
                  tx_state <= HCR_TX_FCS;
               end else if (tx_full && tx_free) begin
                  tx_byte_out <= tx_buf;
                  tx_kind_out <= HCR_KIND_DATA;
                  tx_valid_out <= 1'h1;
                  tx_full <= 1'h0;
                  tx_left <= tx_left - 16'h0001;
               end
            end
            HCR_TX_FCS: if (tx_free) begin
               tx_byte_out <= `HCR_FCS_BYTE;
               tx_kind_out <= HCR_KIND_FCS;
               tx_valid_out <= 1'h1;
               tx_state <= HCR_TX_CLOSE;
            end
            HCR_TX_CLOSE: if (tx_free) begin
               tx_byte_out <= `HCR_FLAG_BYTE;
               tx_kind_out <= HCR_KIND_FLAG;
               tx_valid_out <= 1'h1;
               tx_state <= HCR_TX_DONE;
            end
            HCR_TX_DONE: begin
               tx_ir <= `HCR_TX_DONE_CODE;
               tx_avail <= 1'h1;
               tx_state <= HCR_TX_IDLE;
            end
            default: tx_state <= HCR_TX_IDLE;
         endcase
         if (txd_wr && tx_req) begin
            tx_buf <= link.wdata;
            tx_full <= 1'h1;
         end
      end
   end

   // ==========================================================
   // Receive delivery and results
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_on <= 1'h0;
         rx_cnt <= 16'h0000;
         rx_hdr <= 2'h0;
         rx_a <= 8'h00;
         rx_c <= 8'h00;
         rx_data <= 8'h00;
         rx_full <= 1'h0;
         rq_len <= 3'h0;
         rq_ptr <= 3'h0;
         for (int i = 0; i < 5; i++) begin
            rq[i] <= 8'h00;
         end
      end else begin
         if (rxd_rd) begin
            rx_full <= 1'h0;
         end
         if (rxir_rd && rx_avail) begin
            rq_ptr <= rq_ptr + 3'h1;
         end
         if (rx_start) begin
            rx_on <= 1'h1;
            rx_cnt <= 16'h0000;
            rx_hdr <= 2'h0;
         end else if (rx_on && (abort_hit || rx_end_in)) begin
            rx_on <= 1'h0;
            rq_ptr <= 3'h0;
            rq[0] <= abort_hit ? {3'h0, `HCR_RX_ABORT_CODE} : {rx_end_bits_in, `HCR_RX_DONE_CODE};
            rq[1] <= rx_cnt[7:0];
            rq[2] <= rx_cnt[15:8];
            rq[3] <= rx_a;
            rq[4] <= rx_c;
            rq_len <= abort_hit ? 3'h1 : (buffered ? 3'h5 : 3'h3);
         end else if (rx_on && rx_byte_valid_in) begin
            if (buffered && rx_hdr == 2'h0) begin
               rx_a <= rx_byte_in;
               rx_hdr <= 2'h1;
            end else if (buffered && rx_hdr == 2'h1) begin
               rx_c <= rx_byte_in;
               rx_hdr <= 2'h2;
            end else begin
               rx_data <= rx_byte_in;
               rx_full <= 1'h1;
               rx_cnt <= rx_cnt + 16'h0001;
            end
         end
      end
   end

   // ==========================================================
   // Abort detect and one-bit repeater
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ones <= 4'h0;
         bit_pos <= 3'h0;
         prev_bit <= 1'h1;
         obd_on <= 1'h0;
         delay_bit_out <= 1'h1;
         delay_bit_valid_out <= 1'h0;
         abort_out <= 1'h0;
      end else begin
         abort_out <= abort_hit;
         delay_bit_valid_out <= 1'h0;
         if (!obd_req) begin
            obd_on <= 1'h0;
         end
         if (rx_bit_valid_in) begin
            // Saturate so a long idle run reports a single abort
            ones <= !rx_bit_in ? 4'h0 : (ones == 4'hF ? ones : ones_inc);
            bit_pos <= bit_pos + 3'h1;
            prev_bit <= rx_bit_in;
            if (obd_req && !obd_on && bit_pos == 3'h0) begin
               obd_on <= 1'h1;
            end
            if (obd_on) begin
               delay_bit_out <= prev_bit;
               delay_bit_valid_out <= 1'h1;
            end
         end
      end
   end
endmodule // hcr_device

// ---- core/hcr_host.sv ----
// Purpose: APB bridge that drives the controller's microprocessor bus
// Assumes: One link access per APB transfer
// Notes:   Fixed four-cycle access phase for every transfer
`timescale 1ns/1ns
`include "hcr_regs.svh"
module hcr_host (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Controller bus
   hcr_link_if.host link
);
   import hcr_pkg::*;

   hcr_host_state_type state;
   logic is_pins;

   // ==========================================================
   // Decode
   wire start = psel_in && penable_in && state == HCR_HS_IDLE;
   wire w_ok = paddr_in == `HCR_APB_STATUS || paddr_in == `HCR_APB_RESULT || paddr_in == `HCR_APB_TXIR;
   wire r_link = paddr_in == `HCR_APB_STATUS || paddr_in == `HCR_APB_RESULT || paddr_in == `HCR_APB_TXIR
      || paddr_in == `HCR_APB_RXIR || paddr_in == `HCR_APB_RXDATA;
   wire r_pins = paddr_in == `HCR_APB_PINS;
   wire hit = pwrite_in ? w_ok : (r_link || r_pins);
   wire use_link = pwrite_in ? w_ok : r_link;
   // Writes to the transmit-result offset carry transmit data on the DMA acknowledge
   wire w_txdata = pwrite_in && paddr_in == `HCR_APB_TXIR;
   wire r_rxdata = !pwrite_in && paddr_in == `HCR_APB_RXDATA;
   wire [31:0] pins_word = {28'h0000000, link.rx_drq, link.tx_drq, link.rx_int, link.tx_int};

   assign pready_out = state == HCR_HS_RESP;

   // ==========================================================
   // Sequencer
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state <= HCR_HS_IDLE;
         prdata_out <= 32'h00000000;
         pslverr_out <= 1'h0;
         is_pins <= 1'h0;
         link.cs_n <= 1'h1;
         link.rd_n <= 1'h1;
         link.wr_n <= 1'h1;
         link.addr <= 2'h0;
         link.wdata <= 8'h00;
         link.tx_dack_n <= 1'h1;
         link.rx_dack_n <= 1'h1;
      end else begin
         case (state)
            HCR_HS_IDLE: begin
               if (start) begin
                  state <= HCR_HS_STRB;
                  pslverr_out <= !hit;
                  is_pins <= r_pins;
                  link.addr <= paddr_in[3:2];
                  link.wdata <= pwdata_in[7:0];
                  // Data transfers use acknowledges and leave select high
                  link.cs_n <= !(use_link && !w_txdata && !r_rxdata);
                  link.tx_dack_n <= !w_txdata;
                  link.rx_dack_n <= !r_rxdata;
                  link.wr_n <= !(use_link && pwrite_in);
                  link.rd_n <= !(use_link && !pwrite_in);
               end
            end
            HCR_HS_STRB: begin
               state <= HCR_HS_CAPT;
               link.cs_n <= 1'h1;
               link.rd_n <= 1'h1;
               link.wr_n <= 1'h1;
               link.tx_dack_n <= 1'h1;
               link.rx_dack_n <= 1'h1;
            end
            HCR_HS_CAPT: begin
               state <= HCR_HS_RESP;
               if (pslverr_out || pwrite_in) begin
                  prdata_out <= 32'h00000000;
               end else if (is_pins) begin
                  prdata_out <= pins_word;
               end else begin
                  prdata_out <= {24'h000000, link.rdata};
               end
            end
            HCR_HS_RESP: state <= HCR_HS_IDLE;
            default: state <= HCR_HS_IDLE;
         endcase
      end
   end

endmodule // hcr_host

// ---- bench/hcr_monitor.sv ----
// Purpose: Link checks
// Assumes: One clock
// Notes:   Link signals only
`timescale 1ns/1ns
module hcr_monitor (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Link
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [1:0] addr,
   input wire logic tx_dack_n,
   input wire logic rx_dack_n,
   input wire logic [7:0] rdata,
   input wire logic tx_int,
   input wire logic rx_int,
   input wire logic tx_drq
);
   // ====
   // Checks
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   chk_wr_pulse: assert property ($fell(wr_n) |=> wr_n) else $error("long wr");
   chk_rd_pulse: assert property ($fell(rd_n) |=> rd_n) else $error("long rd");
   chk_txack_wr: assert property (!tx_dack_n |-> !wr_n && rd_n) else $error("tx ack");
   chk_rxack_rd: assert property (!rx_dack_n |-> !rd_n && wr_n) else $error("rx ack");
   chk_rdata_cause: assert property (!$stable(rdata) |-> $past(!rd_n)) else $error("rdata");
   chk_txint_clear: assert property ($fell(tx_int) |->
      $past(!rd_n && !cs_n && addr == 2'h2 || !wr_n && !tx_dack_n)) else $error("tx int");
   chk_receive_attention_flag_clear: assert property ($fell(rx_int) |->
      $past(!rd_n && (!cs_n && addr == 2'h3 || !rx_dack_n))) else $error("rx int");
   chk_drq_clear: assert property ($fell(tx_drq) |-> $past(!wr_n && !tx_dack_n)) else $error("drq");
   cover property ($rose(tx_int));
   cover property ($rose(rx_int));
   cover property ($fell(tx_drq));
endmodule // hcr_monitor

// ---- bench/hcr_host_command_result_port_tb.sv ----
// Purpose: Both ends over APB
// Assumes: Bridge sets its own pace
// Notes:   Line side driven here
`timescale 1ns/1ns
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_mismatch++; $display("ERROR %0t %h %h", $time, a, e); end end
module hcr_host_command_result_port_tb;
   logic ref_clk_in = 0;
   logic rst_n_in = 0;
   logic psel = 0, penable = 0, pwrite = 0, pready, tx_ready = 0, rx_bv = 0, rx_end = 0, bit_v = 0, bit_d = 0;
   logic tx_valid, abort, dbit, dvalid;
   logic [7:0] paddr = 8'h00, rx_byte = 8'h00, txb, op_mode, rd, dseq = 8'h00;
   logic [31:0] pwdata = 0, prdata;
   logic [2:0] rx_bits = 3'h0;
   logic [7:0] q[$];
   logic [7:0] exp_tx[5] = '{8'h7E, 8'h31, 8'h32, 8'h00, 8'h7E};
   int n_mismatch = 0, compares = 0, cyc = 0, n_abort = 0, n_dly = 0;
   hcr_link_if lk();
   hcr_host hcr_host_i (.ref_clk_in, .rst_n_in, .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(), .link(lk));
   hcr_device hcr_device_i (.ref_clk_in, .rst_n_in, .link(lk), .port_a_in(8'hA5), .tx_byte_out(txb),
      .tx_kind_out(), .tx_valid_out(tx_valid), .tx_ready_in(tx_ready), .rx_byte_in(rx_byte),
      .rx_byte_valid_in(rx_bv), .rx_end_in(rx_end), .rx_end_bits_in(rx_bits), .rx_bit_in(bit_d),
      .rx_bit_valid_in(bit_v), .delay_bit_out(dbit), .delay_bit_valid_out(dvalid), .abort_out(abort),
      .op_mode_out(op_mode), .sio_mode_out(), .xfer_mode_out());
   hcr_monitor mon (.ref_clk_in, .rst_n_in, .cs_n(lk.cs_n), .rd_n(lk.rd_n), .wr_n(lk.wr_n), .addr(lk.addr),
      .tx_dack_n(lk.tx_dack_n), .rx_dack_n(lk.rx_dack_n), .rdata(lk.rdata), .tx_int(lk.tx_int),
      .rx_int(lk.rx_int), .tx_drq(lk.tx_drq));
   // ====
   // Clock, line side, timeout
   initial forever #4 ref_clk_in = ~ref_clk_in;
   always @(posedge ref_clk_in) begin
      cyc <= cyc + 1;
      tx_ready <= cyc[1]; // Line stalls half the time
      if (tx_valid === 1'b1 && tx_ready === 1'b1) q.push_back(txb);
      if (abort === 1'b1) n_abort++;
      if (dvalid === 1'b1) begin
         n_dly++;
         dseq <= {dseq[6:0], dbit};
      end
      if (cyc == 30000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   task end_of_test();
      if (n_mismatch == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge ref_clk_in);
      penable <= 1;
      do @(posedge ref_clk_in); while (pready !== 1'b1);
      rd = prdata[7:0];
      psel <= 0;
      penable <= 0;
      @(posedge ref_clk_in);
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      apb(0, a, 8'h00);
      `CHK(rd, e)
   endtask
   // ====
   // Sequence
   initial begin
      repeat (10) @(posedge ref_clk_in);
      rst_n_in <= 1;
      @(posedge ref_clk_in);
      rc(8'h00, 8'h00);
      apb(1, 8'h00, 8'h91);
      rc(8'h00, 8'h80);
      apb(1, 8'h04, 8'h24);
      rc(8'h00, 8'h00);
      `CHK(op_mode, 8'h24)
      apb(1, 8'h00, 8'h51);
      apb(1, 8'h04, 8'hFB);
      rc(8'h00, 8'h00);
      `CHK(op_mode, 8'h20)
      apb(1, 8'h00, 8'h22);
      rc(8'h00, 8'h10);
      rc(8'h04, 8'hA5);
      apb(1, 8'h00, 8'hC8);
      apb(1, 8'h04, 8'h02);
      apb(1, 8'h04, 8'h00);
      for (int i = 0; i < 2; i++) begin
         while (lk.tx_drq !== 1'b1) @(posedge ref_clk_in);
         apb(1, 8'h08, 8'h31 + 8'(i));
      end
      while (lk.tx_int !== 1'b1) @(posedge ref_clk_in);
      rc(8'h00, 8'h05);
      rc(8'h08, 8'h0C);
      rc(8'h00, 8'h00);
      foreach (exp_tx[i]) `CHK(q[i], exp_tx[i])
      // Data transfer mode: receive byte raises the attention pin
      apb(1, 8'h00, 8'h97);
      apb(1, 8'h00, 8'hC0);
      apb(1, 8'h04, 8'h00);
      apb(1, 8'h04, 8'h01);
      rx_byte <= 8'h5A;
      rx_bv <= 1;
      @(posedge ref_clk_in);
      rx_bv <= 0;
      while (lk.rx_int !== 1'b1) @(posedge ref_clk_in);
      rc(8'h00, 8'h08);
      rc(8'h14, 8'h02);
      rc(8'h10, 8'h5A);
      rx_bits <= 3'h3;
      rx_end <= 1;
      @(posedge ref_clk_in);
      rx_end <= 0;
      while (lk.rx_int !== 1'b1) @(posedge ref_clk_in);
      rc(8'h00, 8'h0A);
      rc(8'h0C, 8'h60);
      rc(8'h0C, 8'h01);
      rc(8'h0C, 8'h00);
      rc(8'h00, 8'h00);
      apb(1, 8'h00, 8'hA4);
      for (int i = 0; i < 8; i++) begin
         bit_d <= (i != 0);
         bit_v <= 1;
         @(posedge ref_clk_in);
         bit_v <= 0;
         @(posedge ref_clk_in);
      end
      repeat (3) @(posedge ref_clk_in);
      `CHK(n_abort, 1)
      `CHK(n_dly, 7)
      `CHK(dseq, 8'h3F)
      end_of_test();
   end
endmodule // hcr_host_command_result_port_tb
